// File: hw/slps_pkg.sv
package slps_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_IDENT    = 10'h206;
  localparam logic [9:0] IDX_EOF      = 10'h207;
  localparam logic [9:0] IDX_STATUS   = 10'h208;
  localparam logic [9:0] IDX_CTRL     = 10'h210;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h211;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h212;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_IDENT    = 8'h00;
  localparam logic [7:0] RST_EOF      = 8'h00;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ST_LINK_UP   = 6;
  localparam int ST_SYNC      = 5;
  localparam int ST_REALIGN   = 4;
  localparam int ST_PHASE     = 3;
  localparam int ST_SPLL      = 2;
  localparam int ST_CPLL      = 0;
  localparam int CTRL_ENC_EN  = 0;
  localparam int CTRL_8B10B   = 1;
  localparam int IRQ_REALIGN  = 0;
  localparam int IRQ_PHASE    = 1;
  localparam int IRQ_LINK_DN  = 2;
  localparam int IRQ_PLL_DN   = 3;
  localparam int IRQ_W        = 4;
  localparam int EOF_SEL_LSB  = 0;

  // ---------------------------------------------------------------
  // Frame-end comma selection and control characters
  // ---------------------------------------------------------------
  localparam logic [1:0] EOF_K28_7 = 2'h0;
  localparam logic [1:0] EOF_K28_1 = 2'h1;
  localparam logic [1:0] EOF_K28_5 = 2'h2;
  localparam logic [7:0] K28_7     = 8'hFC;
  localparam logic [7:0] K28_1     = 8'h3C;
  localparam logic [7:0] K28_5     = 8'hBC;

  // Reserved code falls back to the compliant comma
  function automatic logic [7:0] slps_comma_code(input logic [1:0] sel);
    slps_comma_code = (sel == EOF_K28_1) ? K28_1 :
                      (sel == EOF_K28_5) ? K28_5 : K28_7;
  endfunction

endpackage

// File: hw/slps_char_if.sv
`timescale 1ns/100ps
`default_nettype none
interface slps_char_if;
  logic [7:0] ila_ident;
  logic [1:0] comma_sel;
  logic       enc_en;
  logic       use_8b10b;
  modport ctrl (output ila_ident, output comma_sel, output enc_en, output use_8b10b);
  modport path (input ila_ident, input comma_sel, input enc_en, input use_8b10b);
endinterface
`default_nettype wire

// File: hw/slps_char_path.sv
`timescale 1ns/100ps
`default_nettype none
module slps_char_path (
  input  wire logic       clk,                 // Core clock
  input  wire logic       rst_n,               // Async reset, active low
  slps_char_if.path       cfg,                 // Settings from the register bank
  input  wire logic [7:0] tx_octet_i,          // Octet from the framer
  input  wire logic       tx_k_i,              // Octet is a control character
  input  wire logic       tx_valid_i,          // Octet valid
  input  wire logic       tx_frame_end_i,      // Octet is the last of its frame
  input  wire logic       tx_ila_ident_slot_i, // Identifier slot of ILA multiframe two
  output logic      [7:0] tx_octet_o,          // Octet to the encoder
  output logic            tx_k_o,              // Control flag to the encoder
  output logic            tx_valid_o           // Octet valid to the encoder
);

  // -----------------------------------------------------------------
  // Substitution decisions
  // -----------------------------------------------------------------
  logic [7:0] prev_end_q;
  logic       prev_vld_q;
  wire        ident_now = cfg.enc_en & tx_valid_i & tx_ila_ident_slot_i;
  wire        end_now   = tx_valid_i & tx_frame_end_i & ~tx_k_i & ~tx_ila_ident_slot_i;
  // Only repeat of the previous frame's last octet may become a comma
  wire        repl_now  = cfg.enc_en & cfg.use_8b10b & end_now
                        & prev_vld_q & (tx_octet_i == prev_end_q);
  wire [7:0]  comma     = slps_pkg::slps_comma_code(cfg.comma_sel);
  wire [7:0]  octet_d   = ident_now ? cfg.ila_ident : repl_now ? comma : tx_octet_i;
  wire        k_d       = repl_now | (tx_k_i & ~ident_now);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_octet_o <= 8'h00;
      tx_k_o     <= 1'b0;
      tx_valid_o <= 1'b0;
      prev_end_q <= 8'h00;
      prev_vld_q <= 1'b0;
    end else begin
      tx_octet_o <= octet_d;
      tx_k_o     <= k_d;
      tx_valid_o <= tx_valid_i;
      if (!cfg.enc_en) begin
        prev_vld_q <= 1'b0;
      end else if (end_now) begin
        prev_end_q <= tx_octet_i;
        prev_vld_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ident_sent_a: assert property (
    (cfg.enc_en && tx_valid_i && tx_ila_ident_slot_i)
      |=> (tx_octet_o == $past(cfg.ila_ident)) && !tx_k_o)
    else $error("ILA identifier not transmitted");

  comma_code_a: assert property (
    repl_now |=> tx_k_o && tx_octet_o ==
      ($past(cfg.comma_sel) == 2'h1 ? 8'h3C : $past(cfg.comma_sel) == 2'h2 ? 8'hBC : 8'hFC))
    else $error("Wrong frame-end comma");

  no_comma_66_a: assert property (
    (!cfg.use_8b10b && tx_valid_i && !tx_ila_ident_slot_i)
      |=> tx_octet_o == $past(tx_octet_i) && tx_k_o == $past(tx_k_i))
    else $error("Comma replaced outside 8B/10B mode");

  opportune_a: assert property (
    (end_now && tx_octet_i != prev_end_q) |=> tx_octet_o == $past(tx_octet_i))
    else $error("Frame end replaced without a repeat");

endmodule
`default_nettype wire

// File: hw/slps_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Programmed identifier goes out in the second ILA multiframe.
// - Comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// - Comma selection applies in 8B/10B modes only, ignored in 64B/66B.
// - Frame-end comma replaces the last octet only when data permits.
// - Status bit 6 reads one while the link is up.
// - Status bit 5 reads live sync level, zero means requested.
// - Status bit 4 sets on SYSREF realignment, write one clears.
// - Status bit 3 sets on first SYSREF after enable, write one clears.
// - Status bit 2 reads serializer PLL lock.
// - Status bit 0 reads converter PLL lock.
module slps_regs #(
  parameter int ADDR_W = 12                         // Wishbone byte address width
) (
  input  wire logic              clk,                // Core clock, 250 MHz
  input  wire logic              rst_n,              // Async reset, active low
  input  wire logic [ADDR_W-1:0] wb_adr_i,           // Wishbone byte address
  input  wire logic [31:0]       wb_dat_i,           // Wishbone write data
  output logic      [31:0]       wb_dat_o,           // Wishbone read data
  input  wire logic [3:0]        wb_sel_i,           // Wishbone byte selects
  input  wire logic              wb_we_i,            // Wishbone write enable
  input  wire logic              wb_cyc_i,           // Wishbone cycle
  input  wire logic              wb_stb_i,           // Wishbone strobe
  output logic                   wb_ack_o,           // Wishbone acknowledge
  output logic                   irq_o,              // Level interrupt
  output logic                   link_encoder_enable, // Link encoder enable
  input  wire logic              link_up_i,          // Link established
  input  wire logic              sync_n_i,           // SYNC~ level, low requests sync
  input  wire logic              sysref_realign_i,   // SYSREF realigned clocks, pulse
  input  wire logic              sysref_event_i,     // SYSREF event seen, pulse
  input  wire logic              serializer_pll_lock, // Serializer PLL locked
  input  wire logic              converter_pll_lock, // Converter PLL locked
  input  wire logic [7:0]        tx_octet_i,         // Octet from framer
  input  wire logic              tx_k_i,             // Control character flag
  input  wire logic              tx_valid_i,         // Octet valid
  input  wire logic              tx_frame_end_i,     // Last octet of frame
  input  wire logic              tx_ila_ident_slot_i, // ILA identifier slot
  output logic      [7:0]        tx_octet_o,         // Octet to encoder
  output logic                   tx_k_o,             // Control flag to encoder
  output logic                   tx_valid_o          // Valid to encoder
);

  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  logic            ack_q;
  logic [31:0]     dat_q;
  wire             req      = wb_cyc_i & wb_stb_i;
  wire             req_new  = req & ~ack_q;
  wire             wr_take  = req & ack_q & wb_we_i & wb_sel_i[0];
  wire [9:0]       idx      = wb_adr_i[11:2];
  wire             multiframe_phase_set  = (wb_adr_i[1:0] == 2'h0)
                            & (wb_adr_i[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  wire             sel_ident = multiframe_phase_set & (idx == slps_pkg::IDX_IDENT);
  wire             sel_eof   = multiframe_phase_set & (idx == slps_pkg::IDX_EOF);
  wire             sel_stat  = multiframe_phase_set & (idx == slps_pkg::IDX_STATUS);
  wire             sel_ctrl  = multiframe_phase_set & (idx == slps_pkg::IDX_CTRL);
  wire             sel_istat = multiframe_phase_set & (idx == slps_pkg::IDX_IRQ_STAT);
  wire             sel_imask = multiframe_phase_set & (idx == slps_pkg::IDX_IRQ_MASK);
  wire [7:0]       wd        = wb_dat_i[7:0];

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [7:0]       ident_q;
  logic [7:0]       eof_q;
  logic [7:0]       ctrl_q;
  logic             realign_q;
  logic             phase_q;
  logic             armed_q;
  logic             link_up_q;
  logic             plls_q;
  localparam int    IRQ_W_C = slps_pkg::IRQ_W;
  logic [IRQ_W_C-1:0] istat_q;
  logic [IRQ_W_C-1:0] imask_q;

  wire  enc_en    = ctrl_q[slps_pkg::CTRL_ENC_EN];
  wire  enc_d     = (wr_take & sel_ctrl) ? wd[slps_pkg::CTRL_ENC_EN] : enc_en;
  wire  phase_evt = sysref_event_i & armed_q & enc_en;
  wire  plls_now  = serializer_pll_lock & converter_pll_lock;
  wire  link_dn   = link_up_q & ~link_up_i;
  wire  pll_dn    = plls_q & ~plls_now;
  wire  clr_real  = wr_take & sel_stat & wd[slps_pkg::ST_REALIGN];
  wire  clr_phase = wr_take & sel_stat & wd[slps_pkg::ST_PHASE];
  // Hardware events win over a simultaneous write-one clear
  wire  real_d    = sysref_realign_i | (realign_q & ~clr_real);
  wire  phase_d   = phase_evt | (phase_q & ~clr_phase);
  wire  arm_d     = enc_d & ((~enc_en) | (armed_q & ~sysref_event_i));

  wire [IRQ_W_C-1:0] ievt;
  assign ievt[slps_pkg::IRQ_REALIGN] = sysref_realign_i;
  assign ievt[slps_pkg::IRQ_PHASE]   = phase_evt;
  assign ievt[slps_pkg::IRQ_LINK_DN] = link_dn;
  assign ievt[slps_pkg::IRQ_PLL_DN]  = pll_dn;
  wire [IRQ_W_C-1:0] iclr   = (wr_take & sel_istat) ? wd[IRQ_W_C-1:0] : '0;
  wire [IRQ_W_C-1:0] istat_d = ievt | (istat_q & ~iclr);

  // Live bits come straight from their sources; writes cannot touch them
  wire [7:0] status_rd;
  assign status_rd[7]                   = 1'b0;
  assign status_rd[slps_pkg::ST_LINK_UP] = link_up_i;
  assign status_rd[slps_pkg::ST_SYNC]    = sync_n_i;
  assign status_rd[slps_pkg::ST_REALIGN] = realign_q;
  assign status_rd[slps_pkg::ST_PHASE]   = phase_q;
  assign status_rd[slps_pkg::ST_SPLL]    = serializer_pll_lock;
  assign status_rd[1]                   = 1'b0;
  assign status_rd[slps_pkg::ST_CPLL]    = converter_pll_lock;

  wire [7:0] rd_mux = sel_ident ? ident_q :
                      sel_eof   ? eof_q :
                      sel_stat  ? status_rd :
                      sel_ctrl  ? ctrl_q :
                      sel_istat ? {4'h0, istat_q} :
                      sel_imask ? {4'h0, imask_q} : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        dat_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ident_q <= slps_pkg::RST_IDENT;
      eof_q   <= slps_pkg::RST_EOF;
      ctrl_q  <= slps_pkg::RST_CTRL;
      imask_q <= slps_pkg::RST_IRQ_MASK;
    end else if (wr_take) begin
      if (sel_ident) begin
        ident_q <= wd;
      end
      if (sel_eof) begin
        eof_q <= wd;
      end
      if (sel_ctrl) begin
        ctrl_q <= {6'h00, wd[1:0]};
      end
      if (sel_imask) begin
        imask_q <= wd[IRQ_W_C-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      realign_q <= 1'b0;
      phase_q   <= 1'b0;
      armed_q   <= 1'b0;
      link_up_q <= 1'b0;
      plls_q    <= 1'b0;
      istat_q   <= '0;
    end else begin
      realign_q <= real_d;
      phase_q   <= phase_d;
      armed_q   <= arm_d;
      link_up_q <= link_up_i;
      plls_q    <= plls_now;
      istat_q   <= istat_d;
    end
  end

  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = dat_q;
  assign irq_o               = |(istat_q & imask_q);
  assign link_encoder_enable = enc_en;

  // -----------------------------------------------------------------
  // Character path
  // -----------------------------------------------------------------
  slps_char_if cfg_if ();
  assign cfg_if.ila_ident = ident_q;
  assign cfg_if.comma_sel = eof_q[slps_pkg::EOF_SEL_LSB +: 2];
  assign cfg_if.enc_en    = enc_en;
  assign cfg_if.use_8b10b = ctrl_q[slps_pkg::CTRL_8B10B];

  slps_char_path u_path (
    .clk                 (clk),
    .rst_n               (rst_n),
    .cfg                 (cfg_if.path),
    .tx_octet_i          (tx_octet_i),
    .tx_k_i              (tx_k_i),
    .tx_valid_i          (tx_valid_i),
    .tx_frame_end_i      (tx_frame_end_i),
    .tx_ila_ident_slot_i (tx_ila_ident_slot_i),
    .tx_octet_o          (tx_octet_o),
    .tx_k_o              (tx_k_o),
    .tx_valid_o          (tx_valid_o)
  );

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_stat_read;
    req_new && !wb_we_i && sel_stat;
  endsequence

  link_up_rd_a: assert property (
    s_stat_read |=> wb_ack_o && wb_dat_o[6] == $past(link_up_i))
    else $error("Link-up status bit wrong");

  sync_rd_a: assert property (
    s_stat_read |=> wb_dat_o[5] == $past(sync_n_i))
    else $error("Sync status bit wrong");

  spll_rd_a: assert property (
    s_stat_read |=> wb_dat_o[2] == $past(serializer_pll_lock) && wb_dat_o[1] == 1'b0)
    else $error("Serializer lock bit wrong");

  cpll_rd_a: assert property (
    s_stat_read |=> wb_dat_o[0] == $past(converter_pll_lock) && wb_dat_o[7] == 1'b0)
    else $error("Converter lock bit wrong");

  realign_set_a: assert property (
    sysref_realign_i |=> realign_q [*1] ##1 (realign_q || $past(clr_real)))
    else $error("Realign flag not set or lost");

  realign_clr_a: assert property (
    (clr_real && !sysref_realign_i) |=> !realign_q)
    else $error("Realign flag not cleared");

  sequence s_enable_rise;
    !enc_en ##1 enc_en;
  endsequence

  phase_first_a: assert property (
    s_enable_rise ##0 (sysref_event_i && !clr_phase) |=> phase_q)
    else $error("First SYSREF did not mark phase");

  phase_once_a: assert property (
    (!armed_q && !phase_q) |=> !phase_q)
    else $error("Phase flag set without arming");

  live_write_a: assert property (
    (wr_take && sel_stat) |=> $stable(ctrl_q) && $stable(ident_q))
    else $error("Status write leaked into settings");

endmodule
`default_nettype wire

// File: bench/slps_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module slps_rx_model (
  input  wire logic       clk,      // Core clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic       sync_go,  // Bench lets the receiver finish sync
  input  wire logic [7:0] rx_octet, // Octet from the transmitter
  input  wire logic       rx_k,     // Control character flag
  input  wire logic       rx_valid, // Octet valid
  output logic            sync_n,   // Sync request, low requests
  output logic            link_up,  // Receiver sees a running link
  output logic      [8:0] rx_last   // Last received {k, octet}
);
  logic link_q;
  logic link_d;

  // ---------------------------------------------------------------
  // Sync request and link state
  // ---------------------------------------------------------------
  assign sync_n  = sync_go;
  assign link_d  = sync_go & (link_q | rx_valid);
  assign link_up = link_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q  <= 1'b0;
      rx_last <= 9'h000;
    end else begin
      link_q <= link_d;
      if (rx_valid) begin
        rx_last <= {rx_k, rx_octet};
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/serial_link_param_status_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_link_param_status_regs_tb;
  logic clk, rst_n, cyc, stb, we, ack, irq, enc_en, sync_go;
  logic link_up, sync_n, realign, sysref, spll, cpll;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0] sel;
  logic [7:0] oct_i, oct_o;
  logic k_i, v_i, fe_i, slot_i, k_o, v_o;
  logic [8:0] rx_last;
  logic [7:0] cm [4];
  int failures, cmp_count, cyc_cnt;

  slps_regs #(.ADDR_W(12)) u_dut (
    .clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .irq_o(irq), .link_encoder_enable(enc_en), .link_up_i(link_up), .sync_n_i(sync_n),
    .sysref_realign_i(realign), .sysref_event_i(sysref), .serializer_pll_lock(spll),
    .converter_pll_lock(cpll), .tx_octet_i(oct_i), .tx_k_i(k_i), .tx_valid_i(v_i),
    .tx_frame_end_i(fe_i), .tx_ila_ident_slot_i(slot_i), .tx_octet_o(oct_o),
    .tx_k_o(k_o), .tx_valid_o(v_o));

  slps_rx_model u_rx (
    .clk(clk), .rst_n(rst_n), .sync_go(sync_go), .rx_octet(oct_o), .rx_k(k_o),
    .rx_valid(v_o), .sync_n(sync_n), .link_up(link_up), .rx_last(rx_last));

  // ---------------------------------------------------------------
  // Clock, reset and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures = failures + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Compare tasks
  // ---------------------------------------------------------------
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ---------------------------------------------------------------
  // Wishbone classic single cycle and octet driver
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    sel  <= 4'hF;
    // Wait for ack; a wait that never sees ack is ended only by the hang guard
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk_val(what, {24'h000000, exp}, rd);
  endtask

  task automatic send(input logic [7:0] o, input logic fe, input logic sl,
                      input logic [7:0] eo, input logic ek);
    @(posedge clk);
    oct_i  <= o;
    v_i    <= 1'b1;
    fe_i   <= fe;
    slot_i <= sl;
    @(posedge clk);
    v_i <= 1'b0;
    @(negedge clk);
    chk_val("tx_octet_o", {24'h000000, eo}, {24'h000000, oct_o});
    chk_bit("tx_k_o", ek, k_o);
    chk_bit("tx_valid_o", 1'b1, v_o);
  endtask

  task automatic pulse_sysref(input logic re);
    @(posedge clk);
    if (re) realign <= 1'b1;
    else sysref <= 1'b1;
    @(posedge clk);
    realign <= 1'b0;
    sysref  <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, cyc, stb, we, sync_go, realign, sysref, spll, cpll} = 9'h000;
    {oct_i, k_i, v_i, fe_i, slot_i} = 12'h000;
    adr = 12'h000;
    wdat = 32'h00000000;
    sel = 4'h0;
    failures = 0;
    cmp_count = 0;
    cyc_cnt = 0;
    cm = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ident reset", slps_pkg::IDX_IDENT, 8'h00);
    rd_chk("eof reset", slps_pkg::IDX_EOF, 8'h00);
    rd_chk("status reset", slps_pkg::IDX_STATUS, 8'h00);
    rd_chk("ctrl reset", slps_pkg::IDX_CTRL, 8'h00);
    rd_chk("mask reset", slps_pkg::IDX_IRQ_MASK, 8'h00);
    wb(1'b1, slps_pkg::IDX_IDENT, 8'hA5);
    rd_chk("ident rw", slps_pkg::IDX_IDENT, 8'hA5);
    spll <= 1'b1;
    cpll <= 1'b1;
    sync_go <= 1'b1;
    send(8'h12, 1'b0, 1'b0, 8'h12, 1'b0);
    rd_chk("status live", slps_pkg::IDX_STATUS, 8'h65);
    wb(1'b1, slps_pkg::IDX_STATUS, 8'hFF);
    rd_chk("status wr", slps_pkg::IDX_STATUS, 8'h65);
    pulse_sysref(1'b1);
    rd_chk("realign set", slps_pkg::IDX_STATUS, 8'h75);
    chk_bit("irq masked", 1'b0, irq);
    wb(1'b1, slps_pkg::IDX_IRQ_MASK, 8'h01);
    rd_chk("irq stat", slps_pkg::IDX_IRQ_STAT, 8'h01);
    chk_bit("irq raised", 1'b1, irq);
    wb(1'b1, slps_pkg::IDX_STATUS, 8'h10);
    rd_chk("realign clr", slps_pkg::IDX_STATUS, 8'h65);
    wb(1'b1, slps_pkg::IDX_IRQ_STAT, 8'h0F);
    rd_chk("irq clr", slps_pkg::IDX_IRQ_STAT, 8'h00);
    chk_bit("irq low", 1'b0, irq);
    wb(1'b1, slps_pkg::IDX_CTRL, 8'h03);
    @(negedge clk);
    chk_bit("encoder enable", 1'b1, enc_en);
    rd_chk("no phase yet", slps_pkg::IDX_STATUS, 8'h65);
    pulse_sysref(1'b0);
    rd_chk("phase set", slps_pkg::IDX_STATUS, 8'h6D);
    wb(1'b1, slps_pkg::IDX_STATUS, 8'h08);
    pulse_sysref(1'b0);
    rd_chk("phase once", slps_pkg::IDX_STATUS, 8'h65);
    send(8'h11, 1'b0, 1'b1, 8'hA5, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, slps_pkg::IDX_CTRL, 8'h00);
      wb(1'b1, slps_pkg::IDX_EOF, 8'(s));
      rd_chk("eof rw", slps_pkg::IDX_EOF, 8'(s));
      wb(1'b1, slps_pkg::IDX_CTRL, 8'h03);
      send(8'h55, 1'b1, 1'b0, 8'h55, 1'b0);
      send(8'h55, 1'b1, 1'b0, cm[s], 1'b1);
      @(negedge clk);
      chk_val("rx comma", {23'h000000, 1'b1, cm[s]}, {23'h000000, rx_last});
      send(8'h66, 1'b1, 1'b0, 8'h66, 1'b0);
    end
    wb(1'b1, slps_pkg::IDX_CTRL, 8'h00);
    wb(1'b1, slps_pkg::IDX_CTRL, 8'h01);
    send(8'h55, 1'b1, 1'b0, 8'h55, 1'b0);
    send(8'h55, 1'b1, 1'b0, 8'h55, 1'b0);
    wb(1'b1, 10'h300, 8'h5A);
    rd_chk("unmapped", 10'h300, 8'h00);
    rd_chk("ident kept", slps_pkg::IDX_IDENT, 8'hA5);
    sync_go <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("link lost", slps_pkg::IDX_STATUS, 8'h05);
    rd_chk("irq link", slps_pkg::IDX_IRQ_STAT, 8'h06);
    cpll <= 1'b0;
    rd_chk("cpll lost", slps_pkg::IDX_STATUS, 8'h04);
    rd_chk("irq pll", slps_pkg::IDX_IRQ_STAT, 8'h0E);
    complete_run();
  end
endmodule
`default_nettype wire
